// ===== pin_mux.sv
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module pin_mux #(
   parameter logic [1:0] VARIANT = 2'h2
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave.
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Candidate pin levels for routed peripheral inputs.
   input wire pin_mux_pkg::source_pins_type source_pins,
   // Routed peripheral inputs and decoded pin functions.
   output pin_mux_pkg::routed_inputs_type routed_inputs,
   output pin_mux_pkg::pin_functions_type pin_functions
);
   import pin_mux_pkg::*;

   state_type state;
   state_type next_state;

   // Collapses code 01 onto general I/O; lcd_only fields also fold 10 onto I/O.
   function automatic logic [1:0] decode_field(input logic [1:0] code, input logic lcd_only);
      logic [1:0] result;
      result = code;
      if (code == 2'h1) begin
         result = func_gpio;
      end
      if (lcd_only && code == 2'h2) begin
         result = func_gpio;
      end
      return result;
   endfunction : decode_field

   // Takes each input from its selected pin only.
   function automatic logic pick(input logic [1:0] pins, input logic sel);
      return sel ? pins[1] : pins[0];
   endfunction : pick

   function automatic logic [7:0] write_mask(input logic [7:0] addr);
      logic [7:0] mask;
      mask = `FULL_MASK;
      if (addr == `PORT_J_UPPER_OFFSET && VARIANT == `VARIANT_SMALL) begin
         mask = `PORT_J_UPPER_SMALL_MASK;
      end
      if (addr == `TIMER_CLOCK_OFFSET || addr == `TIMER_CAPTURE_OFFSET || addr == `SERIAL_IRQ_OFFSET) begin
         mask = `LOWER_SOURCE_MASK;
      end
      if (addr == `UART_RX_OFFSET) begin
         mask = (VARIANT == `VARIANT_LARGE) ? `UART_RX_FULL_MASK : `UART_RX_SMALL_MASK;
      end
      return mask;
   endfunction : write_mask

   always_comb begin
      logic [7:0] wr_value;
      logic hit;
      wr_value = writedata[7:0] & write_mask(address);
      hit = 1'b1;
      next_state = state;
      next_state.readdata = `UNMAPPED_READ;
      next_state.readdatavalid = 1'b0;
      // One wait cycle per access: answer lands on the second edge.
      next_state.waitrequest = !((read || write) && state.waitrequest);
      if ((read || write) && state.waitrequest) begin
         if (write && byteenable[0]) begin
            unique case (address)
               `PORT_H_UPPER_OFFSET: next_state.regs.port_h_upper_function_select = wr_value;
               `PORT_J_LOWER_OFFSET: next_state.regs.port_j_lower_function_select = wr_value;
               `PORT_J_UPPER_OFFSET: next_state.regs.port_j_upper_function_select = wr_value;
               `TIMER_CLOCK_OFFSET: next_state.regs.timer_clock_source_select = wr_value;
               `TIMER_CAPTURE_OFFSET: next_state.regs.timer_capture_source_select = wr_value;
               `SERIAL_IRQ_OFFSET: next_state.regs.serial_and_irq_source_select = wr_value;
               `UPPER_TIMER_OFFSET: next_state.regs.upper_timer_source_select = wr_value;
               `UART_RX_OFFSET: next_state.regs.uart_rx_source_select = wr_value;
               default: hit = 1'b0;
            endcase
         end
         if (read) begin
            unique case (address)
               `PORT_H_UPPER_OFFSET: next_state.readdata = {24'h00_0000, state.regs.port_h_upper_function_select};
               `PORT_J_LOWER_OFFSET: next_state.readdata = {24'h00_0000, state.regs.port_j_lower_function_select};
               `PORT_J_UPPER_OFFSET: next_state.readdata = {24'h00_0000, state.regs.port_j_upper_function_select};
               `TIMER_CLOCK_OFFSET: next_state.readdata = {24'h00_0000, state.regs.timer_clock_source_select};
               `TIMER_CAPTURE_OFFSET: next_state.readdata = {24'h00_0000, state.regs.timer_capture_source_select};
               `SERIAL_IRQ_OFFSET: next_state.readdata = {24'h00_0000, state.regs.serial_and_irq_source_select};
               `UPPER_TIMER_OFFSET: next_state.readdata = {24'h00_0000, state.regs.upper_timer_source_select};
               `UART_RX_OFFSET: next_state.readdata = {24'h00_0000, state.regs.uart_rx_source_select};
               default: next_state.readdata = `UNMAPPED_READ;
            endcase
            next_state.readdatavalid = 1'b1;
         end
      end
      // Input routing from the current selections.
      for (int i = 0; i < 7; i++) begin
         next_state.routed.timer_clock[i] = pick(source_pins.timer_clock[i],
            state.regs.timer_clock_source_select[i]);
         next_state.routed.timer_capture[i] = pick(source_pins.timer_capture[i],
            state.regs.timer_capture_source_select[i]);
         next_state.routed.serial_irq[i] = pick(source_pins.serial_irq[i],
            state.regs.serial_and_irq_source_select[i]);
      end
      for (int i = 0; i < 8; i++) begin
         next_state.routed.upper_timer[i] = (VARIANT == `VARIANT_SMALL) ? 1'b0 :
            pick(source_pins.upper_timer[i], state.regs.upper_timer_source_select[i]);
      end
      for (int i = 0; i < 3; i++) begin
         next_state.routed.uart_rx[i] = pick(source_pins.uart_rx[i], state.regs.uart_rx_source_select[i]);
      end
      if (VARIANT != `VARIANT_LARGE) begin
         next_state.routed.uart_rx[2] = source_pins.uart_rx[2][0];
      end
      // Port H upper: pins 7/6 have alternate timer outputs, 5/4 analog channels.
      for (int i = 0; i < 4; i++) begin
         next_state.funcs.port_h_upper[i] = decode_field(
            state.regs.port_h_upper_function_select[2*i +: 2], 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         next_state.funcs.port_j[i] = decode_field(
            state.regs.port_j_lower_function_select[2*i +: 2], 1'b0);
         next_state.funcs.port_j[i+4] = decode_field(
            state.regs.port_j_upper_function_select[2*i +: 2], 1'b1);
      end
      if (rst) begin
         next_state.regs = '0;
         next_state.readdata = `UNMAPPED_READ;
         next_state.readdatavalid = 1'b0;
         next_state.waitrequest = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      state <= next_state;
   end

   assign readdata = state.readdata;
   assign waitrequest = state.waitrequest;
   assign routed_inputs = state.routed;
   assign pin_functions = state.funcs;
endmodule : pin_mux

// ===== pin_mux_defs.svh
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH
`define PORT_H_UPPER_OFFSET 8'h00
`define PORT_J_LOWER_OFFSET 8'h04
`define PORT_J_UPPER_OFFSET 8'h08
`define TIMER_CLOCK_OFFSET 8'h0c
`define TIMER_CAPTURE_OFFSET 8'h10
`define SERIAL_IRQ_OFFSET 8'h14
`define UPPER_TIMER_OFFSET 8'h18
`define UART_RX_OFFSET 8'h1c
`define SELECT_RESET 8'h00
`define LOWER_SOURCE_MASK 8'h7f
`define PORT_J_UPPER_SMALL_MASK 8'hf0
`define UART_RX_SMALL_MASK 8'h03
`define UART_RX_FULL_MASK 8'h07
`define FULL_MASK 8'hff
`define VARIANT_SMALL 2'h0
`define VARIANT_MID 2'h1
`define VARIANT_LARGE 2'h2
`define UNMAPPED_READ 32'h0000_0000
`endif

// ===== pin_mux_pkg.sv
package pin_mux_pkg;
   // Function chosen for one multiplexed pin.
   typedef enum logic [1:0] {
      func_gpio = 2'h0,
      func_alt = 2'h2,
      func_lcd = 2'h3
   } pin_func_type;

   typedef struct packed {
      logic [7:0] port_h_upper_function_select;
      logic [7:0] port_j_lower_function_select;
      logic [7:0] port_j_upper_function_select;
      logic [7:0] timer_clock_source_select;
      logic [7:0] timer_capture_source_select;
      logic [7:0] serial_and_irq_source_select;
      logic [7:0] upper_timer_source_select;
      logic [7:0] uart_rx_source_select;
   } select_regs_type;

   // Candidate pin pairs: bit 0 is the primary pin, bit 1 the alternate.
   typedef struct packed {
      logic [6:0][1:0] timer_clock;
      logic [6:0][1:0] timer_capture;
      logic [6:0][1:0] serial_irq;
      logic [7:0][1:0] upper_timer;
      logic [2:0][1:0] uart_rx;
   } source_pins_type;

   typedef struct packed {
      logic [6:0] timer_clock;
      logic [6:0] timer_capture;
      logic [6:0] serial_irq;
      logic [7:0] upper_timer;
      logic [2:0] uart_rx;
   } routed_inputs_type;

   // Decoded function of each pin: port H 7..4, port J 7..0.
   typedef struct packed {
      logic [3:0][1:0] port_h_upper;
      logic [7:0][1:0] port_j;
   } pin_functions_type;

   typedef struct packed {
      select_regs_type regs;
      routed_inputs_type routed;
      pin_functions_type funcs;
      logic [31:0] readdata;
      logic readdatavalid;
      logic waitrequest;
   } state_type;
endpackage : pin_mux_pkg

// ===== pin_mux_assertions.sv
`timescale 1ns/1ps
module pin_mux_assertions (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Bus.
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Pins.
   input wire pin_mux_pkg::source_pins_type source_pins,
   input wire pin_mux_pkg::routed_inputs_type routed_inputs,
   input wire pin_mux_pkg::pin_functions_type pin_functions
);
   import pin_mux_pkg::*;
   logic [1:0] rx1_pins;
   logic [1:0] clk3_pins;
   assign rx1_pins = source_pins.uart_rx[1];
   assign clk3_pins = source_pins.timer_clock[3];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("access not answered");
   chk_answer_once: assert property (!waitrequest |=> waitrequest)
      else $error("answer held too long");
   chk_unmapped_zero: assert property (read && waitrequest && address == 8'h20 |=> readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_clock_top: assert property (read && waitrequest && address == 8'h0c |=> readdata[31:7] == 25'h0)
      else $error("timer clock top bit not zero");
   chk_rx_upper: assert property (read && waitrequest && address == 8'h1c |=> readdata[31:3] == 29'h0)
      else $error("receive select upper bits not zero");
   chk_pj7_code: assert property (pin_functions.port_j[7] inside {func_gpio, func_lcd})
      else $error("port j pin 7 function illegal");
   chk_pj5_code: assert property (pin_functions.port_j[5] inside {func_gpio, func_lcd})
      else $error("port j pin 5 function illegal");
   chk_ph_code: assert property (pin_functions.port_h_upper[1] != 2'h1)
      else $error("port h pin 5 function illegal");
   chk_rx_agree: assert property (!$past(rst) && $past(rx1_pins[1]) == $past(rx1_pins[0])
      |-> routed_inputs.uart_rx[1] == $past(rx1_pins[0])) else $error("receive route wrong");
   chk_clk_agree: assert property (!$past(rst) && $past(clk3_pins[1]) == $past(clk3_pins[0])
      |-> routed_inputs.timer_clock[3] == $past(clk3_pins[0])) else $error("clock route wrong");
   cover property (read && !waitrequest);
   cover property (write && !waitrequest);
   cover property (pin_functions.port_j[7] == func_lcd);
endmodule : pin_mux_assertions

bind pin_mux pin_mux_assertions u_chk (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
   .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .source_pins(source_pins), .routed_inputs(routed_inputs), .pin_functions(pin_functions));

// ===== tb_pin_mux.sv
`timescale 1ns/1ps
module tb_pin_mux;
   import pin_mux_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'h1;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata;
   logic waitrequest;
   source_pins_type source_pins = '0;
   routed_inputs_type routed_inputs;
   pin_functions_type pin_functions;
   int fails = 0;
   int comparisons = 0;
   logic [31:0] rd;
   logic [7:0] mask [8] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h7f, 8'hff, 8'h07};
   logic [31:0] readdata_small;
   logic waitrequest_small;
   routed_inputs_type routed_small;
   pin_functions_type functions_small;
   logic [31:0] rd_small;
   logic [7:0] mask_small [8] = '{8'hff, 8'hff, 8'hf0, 8'h7f, 8'h7f, 8'h7f, 8'hff, 8'h03};
   pin_mux dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write), .byteenable(byteenable),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .source_pins(source_pins),
      .routed_inputs(routed_inputs), .pin_functions(pin_functions));
   // The smallest variant shares the bus and pins so that its masked fields are judged too.
   pin_mux #(.VARIANT(2'h0)) dut_small (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata_small), .waitrequest(waitrequest_small),
      .source_pins(source_pins), .routed_inputs(routed_small), .pin_functions(functions_small));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Holds the request until waitrequest is sampled low, then releases it.
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      address <= addr;
      writedata <= data;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0);
      check("answer edges", n, 32'h0000_0002);
      check("small waitrequest", {31'h0, waitrequest_small}, 32'h0000_0000);
      rd = readdata;
      rd_small = readdata_small;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic test_reset();
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0000_0000);
         check("reset value", rd, 32'h0000_0000);
         check("small reset value", rd_small, 32'h0000_0000);
      end
   endtask : test_reset
   task automatic test_readback();
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 8'(i * 4), 32'h0000_00ff);
         bus(1'b0, 8'(i * 4), 32'h0000_0000);
         check("readback", rd, {24'h0, mask[i]});
         check("small readback", rd_small, {24'h0, mask_small[i]});
      end
      bus(1'b1, 8'h20, 32'h0000_00ff);
      bus(1'b0, 8'h20, 32'h0000_0000);
      check("unmapped", rd, 32'h0000_0000);
      check("small unmapped", rd_small, 32'h0000_0000);
   endtask : test_readback
   // Writes with lane 0 disabled are dropped; a reset in mid-run clears the port H upper field, the only one read back.
   task automatic test_lane_reset();
      bus(1'b1, 8'h00, 32'h0000_00a5);
      byteenable <= 4'he;
      @(posedge clk);
      bus(1'b1, 8'h00, 32'h0000_005a);
      byteenable <= 4'h1;
      @(posedge clk);
      bus(1'b0, 8'h00, 32'h0000_0000);
      check("lane drop", rd, 32'h0000_00a5);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      check("reset waitrequest", {31'h0, waitrequest}, 32'h0000_0001);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, 8'h00, 32'h0000_0000);
      check("mid reset", rd, 32'h0000_0000);
      check("small mid reset", rd_small, 32'h0000_0000);
   endtask : test_lane_reset
   task automatic test_functions();
      logic [1:0] e;
      for (int c = 0; c < 4; c++) begin
         e = (c == 1) ? 2'h0 : 2'(c);
         bus(1'b1, 8'h00, {24'h0, {4{2'(c)}}});
         bus(1'b1, 8'h04, {24'h0, {4{2'(c)}}});
         bus(1'b1, 8'h08, {24'h0, {4{2'(c)}}});
         repeat (2) @(posedge clk);
         check("port h", 32'(pin_functions.port_h_upper), {24'h0, {4{e}}});
         check("port j low", 32'(pin_functions.port_j[3:0]), {24'h0, {4{e}}});
         check("port j up", 32'(pin_functions.port_j[7:4]), {24'h0, {4{(c == 3) ? 2'h3 : 2'h0}}});
         check("small port j up", 32'(functions_small.port_j[7:4]), {24'h0, (c == 3) ? 8'hf0 : 8'h00});
      end
   endtask : test_functions
   task automatic test_routing();
      logic x;
      for (int s = 0; s < 2; s++) begin
         for (int i = 3; i < 8; i++) begin
            bus(1'b1, 8'(i * 4), (s == 1) ? 32'h0000_00ff : 32'h0000_0000);
         end
         for (int p = 0; p < 2; p++) begin
            source_pins <= {32{~p[0], p[0]}};
            repeat (3) @(posedge clk);
            x = (s == 1) ? ~p[0] : p[0];
            check("routed", 32'(routed_inputs), {32{x}});
            check("small routed", 32'(routed_small), {{21{x}}, 8'h00, p[0], x, x});
         end
      end
   endtask : test_routing
   task automatic end_sim();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim
   initial begin
      #400000;
      fails++;
      end_sim();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      test_reset();
      test_readback();
      test_lane_reset();
      test_functions();
      test_routing();
      end_sim();
   end
endmodule : tb_pin_mux
